// ===== dv/ctrl_model.sv
// Memory controller model: drives the port's pins once per clock.
// Assumes the bench calls step for every clock; write data trails by two live edges.
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk_in,
  output logic qual_n_out,
  output logic adv_out,
  output logic write_n_out,
  output logic [2:0] sel_out,
  output logic [17:0] addr_out,
  output logic [1:0] lane_n_out,
  output logic [1:0] parity_out,
  output logic [15:0] data_out
);
  logic [20:0] pipe0 = '0;
  logic [20:0] pipe1 = '0;
  initial
  begin
    {qual_n_out, adv_out, write_n_out, sel_out, addr_out} = {3'h1, 3'h5, 18'h0};
    {lane_n_out, parity_out, data_out} = {2'h3, 2'h0, 16'h0};
  end
  task automatic step(input logic q_n, adv, we_n, wr, input logic [2:0] cs, input logic [17:0] a,
                      input logic [1:0] ln, p, input logic [15:0] d);
    @(negedge clk_in);
    qual_n_out = q_n;
    adv_out = adv;
    write_n_out = we_n;
    sel_out = cs;
    addr_out = a;
    if (pipe1[20])
      {lane_n_out, parity_out, data_out} = pipe1[19:0];
    else
    begin
      // Released bus shows a changing pattern, not the last value
      lane_n_out = 2'h3;
      parity_out = ~parity_out;
      data_out = ~data_out;
    end
    if (!q_n)
    begin
      pipe1 = pipe0;
      pipe0 = {wr, ln, p, d};
    end
    @(posedge clk_in);
    #1;
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the pipelined burst memory port.
// Assumes ctrl_model drives the pins; clock enable is held high.
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DESEL = 3'h5;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic oe_n = 1'b0;
  logic mode = 1'b1;
  logic qual_n, adv, write_n, data_oe, par_oe;
  logic [2:0] sel;
  logic [17:0] addr;
  logic [1:0] lane_n, par_m, par_q;
  logic [15:0] data_m, data_q;
  wire logic [15:0] data_pin = data_oe ? data_q : data_m;
  wire logic [1:0] par_pin = par_oe ? par_q : par_m;
  int fail_count = 0;
  int comparisons = 0;
  ctrl_model ctrl (
    .clk_in(clk_in),
    .qual_n_out(qual_n),
    .adv_out(adv),
    .write_n_out(write_n),
    .sel_out(sel),
    .addr_out(addr),
    .lane_n_out(lane_n),
    .parity_out(par_m),
    .data_out(data_m)
  );
  pipelined_burst_sram_port uut (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(1'b1),
    .clk_qualify_n_in(qual_n),
    .addr_in(addr),
    .write_n_in(write_n),
    .byte_lane_sel_n_in(lane_n),
    .advance_or_load_in(adv),
    .chip_sel_a_n_in(sel[2]),
    .chip_sel_b_in(sel[1]),
    .chip_sel_c_n_in(sel[0]),
    .out_enable_n_in(oe_n),
    .burst_mode_in(mode),
    .data_in(data_pin),
    .data_out(data_q),
    .data_oe_out(data_oe),
    .parity_io_in(par_pin),
    .parity_io_out(par_q),
    .parity_io_oe_out(par_oe)
  );
  initial
    forever #50 clk_in = ~clk_in;
  task automatic check(input logic [17:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic word(input logic [17:0] exp);
    check({par_q, data_q}, exp);
  endtask
  task automatic seen_oe(input logic e);
    check({16'h0, par_oe, data_oe}, {16'h0, e, e});
  endtask
  task automatic rd(input logic [17:0] a);
    ctrl.step(1'b0, 1'b0, 1'b1, 1'b0, SEL, a, 2'h3, 2'h0, 16'h0);
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] p, ln);
    ctrl.step(1'b0, 1'b0, 1'b0, 1'b1, SEL, a, ln, p, d);
  endtask
  task automatic ds();
    ctrl.step(1'b0, 1'b0, 1'b1, 1'b0, DESEL, 18'h0, 2'h3, 2'h0, 16'h0);
  endtask
  task automatic do_reset(input logic m);
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    mode = m;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask
  task automatic t_pipeline();
    wr(18'h00010, 16'h1234, 2'h1, 2'h0);
    wr(18'h00011, 16'h5678, 2'h2, 2'h0);
    rd(18'h00010);
    seen_oe(1'b0);
    rd(18'h00011);
    word({2'h1, 16'h1234});
    seen_oe(1'b1);
    ds();
    word({2'h2, 16'h5678});
    seen_oe(1'b1);
    ds();
    seen_oe(1'b0);
  endtask
  task automatic t_lanes();
    wr(18'h00020, 16'h1234, 2'h3, 2'h0);
    wr(18'h00020, 16'habcd, 2'h0, 2'h2);
    wr(18'h00020, 16'h9955, 2'h1, 2'h1);
    ds();
    ds();
    rd(18'h00020);
    ds();
    word({2'h0, 16'h99cd});
  endtask
  task automatic t_suspend();
    wr(18'h00030, 16'h0f0f, 2'h3, 2'h0);
    ds();
    ds();
    rd(18'h00030);
    repeat (3) ctrl.step(1'b1, 1'b0, 1'b0, 1'b1, SEL, 18'h00020, 2'h0, 2'h3, 16'hffff);
    word({2'h0, 16'h99cd});
    ds();
    word({2'h3, 16'h0f0f});
    ds();
    ds();
    rd(18'h00020);
    ds();
    word({2'h0, 16'h99cd});
  endtask
  task automatic t_select();
    for (int c = 0; c < 8; c++)
    begin
      if (c == 2)
        continue;
      ds();
      ctrl.step(1'b0, 1'b0, 1'b1, 1'b0, 3'(c), 18'h00030, 2'h3, 2'h0, 16'h0);
      ds();
      seen_oe(1'b0);
      word({2'h0, 16'h99cd});
    end
    @(negedge clk_in);
    oe_n = 1'b1;
    repeat (3) ds();
    rd(18'h00030);
    ds();
    seen_oe(1'b0);
    word({2'h3, 16'h0f0f});
    @(negedge clk_in);
    oe_n = 1'b0;
    repeat (3) ds();
  endtask
  task automatic t_burst();
    int k;
    for (int i = 0; i < 4; i++)
      ctrl.step(1'b0, i != 0, 1'b0, 1'b1, SEL, 18'h00101, 2'h0, 2'h0, 16'(16'h0b00 + i));
    ds();
    ds();
    for (int j = 0; j < 6; j++)
    begin
      if (j < 5)
        ctrl.step(1'b0, j != 0, 1'b1, 1'b0, SEL, 18'h00100, 2'h3, 2'h0, 16'h0);
      else
        ds();
      k = (j + 3) % 4;
      if (j > 0)
        word({2'h0, 16'(16'h0b00 + (mode ? (1 ^ k) : (k + 3) % 4))});
    end
  endtask
  initial
  begin
    do_reset(1'b1);
    t_pipeline();
    t_lanes();
    t_suspend();
    t_select();
    t_burst();
    do_reset(1'b0);
    t_burst();
    results();
  end
  initial
  begin
    repeat (2000) @(posedge clk_in);
    fail_count++;
    results();
  end
endmodule

// ===== rtl/burst_order_step.sv
// Burst address step for the two low address bits.
// Assumes a static order select and a beat number from the caller.
`timescale 1ns/1ps
module burst_order_step (
  input wire logic [sram_port_pkg::BEAT_W-1:0] start_in,
  input wire logic [sram_port_pkg::BEAT_W-1:0] beat_in,
  input wire logic interleave_in,
  output logic [sram_port_pkg::BEAT_W-1:0] addr_out
);
  import sram_port_pkg::*;

  always_comb
  begin
    if (interleave_in)
    begin
      addr_out = start_in ^ beat_in;
    end
    else
    begin
      addr_out = BEAT_W'(start_in + beat_in);
    end
  end
endmodule

// ===== rtl/pipelined_burst_sram_port.sv
// Pipelined burst memory port: 256K words of 16 data and 2 parity bits.
// Assumes the controller runs on clk_in; strap and output enable are
// asynchronous and are synchronised here.
`timescale 1ns/1ps
module pipelined_burst_sram_port (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic clk_qualify_n_in,
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr_in,
  input wire logic write_n_in,
  input wire logic [sram_port_pkg::LANES-1:0] byte_lane_sel_n_in,
  input wire logic advance_or_load_in,
  input wire logic chip_sel_a_n_in,
  input wire logic chip_sel_b_in,
  input wire logic chip_sel_c_n_in,
  input wire logic out_enable_n_in,
  input wire logic burst_mode_in,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
  output logic [sram_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [sram_port_pkg::LANES-1:0] parity_io_in,
  output logic [sram_port_pkg::LANES-1:0] parity_io_out,
  output logic parity_io_oe_out
);
  import sram_port_pkg::*;

  typedef struct packed {
    logic [1:0] mode_sync;
    logic [1:0] oe_n_sync;
    logic burst_act;
    logic burst_wr;
    logic [ADDR_W-1:0] base;
    logic [BEAT_W-1:0] beat;
    op_type op;
    logic [ADDR_W-1:0] addr;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_valid;
    logic [ENTRY_W-1:0] wr_entry;
    logic rd_valid;
    logic [WORD_W-1:0] rd_word;
    logic drive;
  } state_type;

  state_type st_q;
  state_type st_d;

  logic run;
  logic sel_w;
  logic drain;
  logic fifo_in_ready;
  logic head_valid;
  logic [ENTRY_W-1:0] head;
  logic [ADDR_W-1:0] head_addr;
  logic [LANES-1:0] head_lanes_n;
  logic [ADDR_W-1:0] ent_addr;
  logic [LANES-1:0] ent_lanes_n;
  logic pend_hit;
  logic ent_hit;
  logic head_hit;
  logic [WORD_W-1:0] in_cells;
  logic [WORD_W-1:0] rd_cells;
  logic [BEAT_W-1:0] step_lo;

  // Effective edge: enabled, qualified, and room to post the write
  assign run = ce_in & ~clk_qualify_n_in & fifo_in_ready;
  assign drain = ce_in & ~clk_qualify_n_in & head_valid;
  assign sel_w = ~chip_sel_a_n_in & chip_sel_b_in & ~chip_sel_c_n_in;

  assign head_addr = head[ENT_ADDR_LSB +: ADDR_W];
  assign head_lanes_n = head[ENT_LANE_LSB +: LANES];
  assign ent_addr = st_q.wr_entry[ENT_ADDR_LSB +: ADDR_W];
  assign ent_lanes_n = st_q.wr_entry[ENT_LANE_LSB +: LANES];

  // Writes not yet in the array, newest first
  assign pend_hit = st_q.wr_pend && st_q.wr_addr == st_q.addr;
  assign ent_hit = st_q.wr_valid && ent_addr == st_q.addr;
  assign head_hit = head_valid && head_addr == st_q.addr;

  // Posted writes; drained one per qualified cycle
  sync_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .in_valid_in(st_q.wr_valid & ~clk_qualify_n_in),
    .in_data_in(st_q.wr_entry),
    .in_ready_out(fifo_in_ready),
    .out_ready_in(~clk_qualify_n_in),
    .out_valid_out(head_valid),
    .out_data_out(head)
  );

  burst_order_step u_step (
    .start_in(st_q.base[BEAT_W-1:0]),
    .beat_in(BEAT_W'(st_q.beat + BEAT_ONE)),
    .interleave_in(st_q.mode_sync[1]),
    .addr_out(step_lo)
  );

  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic [CELL_W-1:0] cells [DEPTH];
    logic [CELL_W-1:0] head_cell;
    logic [CELL_W-1:0] ent_cell;
    logic [CELL_W-1:0] in_cell;
    logic [CELL_W-1:0] rd_cell;

    assign head_cell = head[g*CELL_W +: CELL_W];
    assign ent_cell = st_q.wr_entry[g*CELL_W +: CELL_W];
    assign in_cell = {parity_io_in[g], data_in[g*LANE_W +: LANE_W]};
    assign in_cells[g*CELL_W +: CELL_W] = in_cell;

    // Self-timed array update, per lane
    always_ff @(posedge clk_in)
    begin
      if (drain && !head_lanes_n[g])
      begin
        cells[head_addr] <= head_cell;
      end
    end

    always_comb
    begin
      if (pend_hit && !byte_lane_sel_n_in[g])
      begin
        rd_cell = in_cell;
      end
      else if (ent_hit && !ent_lanes_n[g])
      begin
        rd_cell = ent_cell;
      end
      else if (head_hit && !head_lanes_n[g])
      begin
        rd_cell = head_cell;
      end
      else
      begin
        rd_cell = cells[st_q.addr];
      end
    end

    // One lane slice of the forwarded read word
    assign rd_cells[g*CELL_W +: CELL_W] = rd_cell;

    assign data_out[g*LANE_W +: LANE_W] = st_q.rd_word[g*CELL_W +: LANE_W];
    assign parity_io_out[g] = st_q.rd_word[g*CELL_W + LANE_W];
  end

  assign data_oe_out = st_q.drive;
  assign parity_io_oe_out = st_q.drive;

  always_comb
  begin
    st_d = st_q;
    if (ce_in)
    begin
      st_d.mode_sync = {st_q.mode_sync[0], burst_mode_in};
      st_d.oe_n_sync = {st_q.oe_n_sync[0], out_enable_n_in};
    end
    if (run)
    begin
      // Data phase of the access taken one edge earlier
      st_d.rd_valid = st_q.op == OP_RD;
      if (st_q.op == OP_RD)
      begin
        st_d.rd_word = rd_cells;
      end
      st_d.wr_pend = st_q.op == OP_WR;
      st_d.wr_addr = st_q.addr;
      st_d.wr_valid = st_q.wr_pend;
      if (st_q.wr_pend)
      begin
        st_d.wr_entry = {st_q.wr_addr, byte_lane_sel_n_in, in_cells};
      end
      // Address phase
      if (!advance_or_load_in)
      begin
        if (sel_w)
        begin
          st_d.burst_act = 1'b1;
          st_d.burst_wr = ~write_n_in;
          st_d.base = addr_in;
          st_d.beat = '0;
          st_d.addr = addr_in;
          st_d.op = write_n_in ? OP_RD : OP_WR;
        end
        else
        begin
          st_d.burst_act = 1'b0;
          st_d.op = OP_NONE;
        end
      end
      else if (st_q.burst_act)
      begin
        st_d.beat = BEAT_W'(st_q.beat + BEAT_ONE);
        st_d.addr = {st_q.base[ADDR_W-1:BEAT_W], step_lo};
        st_d.op = st_q.burst_wr ? OP_WR : OP_RD;
      end
      else
      begin
        st_d.op = OP_NONE;
      end
    end
    if (ce_in)
    begin
      // Drivers only carry read data, gated by output enable
      st_d.drive = st_d.rd_valid & ~st_q.oe_n_sync[1];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= '0;
      st_q.mode_sync <= SYNC_HIGH;
      st_q.oe_n_sync <= SYNC_HIGH;
      st_q.op <= OP_NONE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_read_after_load: assert property (
    run && !advance_or_load_in && sel_w && write_n_in ##1 run |=> st_q.rd_valid)
    else $error("read load gave no read data");
  a_read_data_path: assert property (
    run && st_q.op == OP_RD |=> st_q.rd_word == $past(rd_cells))
    else $error("read data not registered");
  a_suspend_hold: assert property (
    ce_in && clk_qualify_n_in |=> $stable(st_q.addr) && $stable(st_q.op) && $stable(st_q.rd_word))
    else $error("state moved while suspended");
  a_edge_qualify: assert property (
    !run |=> $stable(st_q.beat) && $stable(st_q.wr_pend))
    else $error("unqualified edge changed state");
  a_write_capture: assert property (
    run && !advance_or_load_in && sel_w && !write_n_in ##1 run ##1 run
    |=> st_q.wr_valid && ent_addr == $past(addr_in, 3) && ent_lanes_n == $past(byte_lane_sel_n_in))
    else $error("write not captured two edges after address");
  a_write_quiet: assert property (
    st_q.wr_pend |-> !data_oe_out && !parity_io_oe_out)
    else $error("drivers on during write data");
  a_deselect: assert property (
    run && !advance_or_load_in && !sel_w |=> st_q.op == OP_NONE && !st_q.burst_act)
    else $error("deselect not taken");
  a_desel_drive: assert property (
    run && st_q.op == OP_NONE |=> !st_q.rd_valid && !data_oe_out)
    else $error("drivers on after deselect");
  a_oe_mask: assert property (
    ce_in && st_q.oe_n_sync[1] |=> !data_oe_out)
    else $error("drivers on with output enable high");
  a_burst_wrap: assert property (
    run && advance_or_load_in && st_q.burst_act && st_q.beat == BEAT_LAST
    |=> st_q.addr == st_q.base)
    else $error("burst did not wrap to start");
  a_burst_upper: assert property (
    run && advance_or_load_in && st_q.burst_act
    |=> st_q.addr[ADDR_W-1:BEAT_W] == st_q.base[ADDR_W-1:BEAT_W] && st_q.op == $past(st_q.op))
    else $error("burst left its group");
  a_no_wait: assert property (
    ce_in && !clk_qualify_n_in |-> run)
    else $error("wait state inserted");

  // Address phase checks
  a_load_addr: assert property (
    run && !advance_or_load_in && sel_w |=> st_q.addr == $past(addr_in) && st_q.beat == '0)
    else $error("load address not taken");

  a_load_op: assert property (
    run && !advance_or_load_in && sel_w |=> st_q.op == ($past(write_n_in) ? OP_RD : OP_WR))
    else $error("load took wrong access type");

  a_adv_idle: assert property (
    run && advance_or_load_in && !st_q.burst_act |=> st_q.op == OP_NONE)
    else $error("advance without burst started an access");

  a_burst_step: assert property (
    run && advance_or_load_in && st_q.burst_act |=> st_q.beat == BEAT_W'($past(st_q.beat) + BEAT_ONE))
    else $error("burst beat did not step");

  a_op_onehot: assert property (
    $onehot(st_q.op))
    else $error("access type code illegal");

  // Data phase checks
  a_pend_track: assert property (
    run |=> st_q.wr_pend == ($past(st_q.op) == OP_WR))
    else $error("write data phase misplaced");

  a_entry_data: assert property (
    run && st_q.wr_pend
    |=> st_q.wr_entry == {$past(st_q.wr_addr), $past(byte_lane_sel_n_in), $past(in_cells)})
    else $error("write data not captured");

  a_read_drive: assert property (
    run && st_q.op == OP_RD && !st_q.oe_n_sync[1] |=> data_oe_out && st_q.rd_valid)
    else $error("read data not driven");

  a_rd_valid_once: assert property (
    run && st_q.op != OP_RD |=> !st_q.rd_valid)
    else $error("read data flagged without read");

  a_rd_word_hold: assert property (
    !run |=> $stable(st_q.rd_word))
    else $error("read word moved on dead edge");

  a_parity_oe: assert property (
    data_oe_out == parity_io_oe_out)
    else $error("parity drivers differ from data drivers");

  a_fifo_room: assert property (
    fifo_in_ready)
    else $error("write buffer full");

  // Pin synchronisers and clock enable hold
  a_strap_sync: assert property (
    ce_in |=> st_q.mode_sync[1] == $past(st_q.mode_sync[0]))
    else $error("strap synchroniser skipped a stage");

  a_oe_sync: assert property (
    ce_in |=> st_q.oe_n_sync[1] == $past(st_q.oe_n_sync[0]))
    else $error("enable synchroniser skipped a stage");

  a_ce_freeze: assert property (
    !ce_in |=> $stable(st_q))
    else $error("state moved with clock enable low");

  c_read_after_write: cover property (
    run && st_q.op == OP_WR ##1 run && st_q.op == OP_RD && pend_hit);
  c_burst_four: cover property (
    (run && advance_or_load_in && st_q.burst_act)[*4]);
  c_suspend: cover property (
    st_q.rd_valid && ce_in && clk_qualify_n_in ##1 clk_qualify_n_in);
  c_linear_burst: cover property (
    run && advance_or_load_in && st_q.burst_act && !st_q.mode_sync[1]);
  c_deselect_read: cover property (
    run && st_q.op == OP_NONE ##1 run && st_q.op == OP_RD);
endmodule

// ===== rtl/sram_port_pkg.sv
// Constants and types for the pipelined burst memory port.
// Assumes one clock domain shared with the memory controller logic.
// Functional notes
// - Address, controls and write data are captured in registers on the rising edge.
// - Read data leaves the block from output registers loaded on the rising edge.
// - Clock qualifier high suspends all operation and holds every state; the pin synchronisers and driver enable still update.
// - A rising edge counts only when the clock qualifier is low.
// - Write strobe is sampled only on edges where the clock qualifier is low.
// - Lane select 0 writes bits 7:0 and parity 0; lane 1 bits 15:8, parity 1.
// - Writes complete through internal self-timed logic, no pulse timing needed.
// - Data drivers are off during the data portion of every write.
// - Address is 18 bits wide, selecting one of 262144 words.
// - Advance high on an effective edge steps the burst counter.
// - Advance low loads the presented address as a new access.
// - Reads and writes follow in any order every cycle without wait states.
// - Three chip selects select the device; output enable gates the drivers.
// - Selected only with select a low, select b high, select c low.
// - Read data appears in the cycle after the edge following the address edge.
// - Drivers stay off during write data, after deselect and while deselected.
// - Burst order strap: high or floating interleaved, low linear; static.
package sram_port_pkg;
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int CELL_W = LANE_W + 1;
  localparam int WORD_W = LANES * CELL_W;
  localparam int BEAT_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int ENT_LANE_LSB = WORD_W;
  localparam int ENT_ADDR_LSB = ENT_LANE_LSB + LANES;
  localparam int ENTRY_W = ENT_ADDR_LSB + ADDR_W;
  localparam logic [1:0] SYNC_HIGH = 2'h3;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  typedef enum logic [2:0] {OP_NONE = 3'h1, OP_RD = 3'h2, OP_WR = 3'h4} op_type;
endpackage

// ===== rtl/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W:0] cnt;
  } fifo_state_type;

  fifo_state_type st_q;
  fifo_state_type st_d;
  logic push;
  logic pop;

  assign in_ready_out = st_q.cnt != FULL_CNT;
  assign out_valid_out = st_q.cnt != '0;
  assign out_data_out = st_q.mem[st_q.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr] = in_data_in;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop)
    begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= '0;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
    end
  end
endmodule
